// [rtl/period_match_timer.sv]
// Eight-bit period match timer with prescaler and postscaler.
`timescale 1ns/1ps
`default_nettype none

module period_match_timer
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sleep,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   output logic periodMatch,
   output logic pwmPeriodStart,
   output logic irqRequest
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [7:0] count_q;
   logic [7:0] period_q;
   logic [6:0] control_q;
   logic [5:0] preCnt_q;
   logic [3:0] postCnt_q;
   logic matchFlag_q;
   logic irqEnable_q;
   logic reloadPending_q;
   logic [7:0] regRdData_q;
   logic periodMatch_q;
   logic pwmPeriodStart_q;
   logic irqRequest_q;

   logic [1:0] preSel;
   logic [3:0] postSel;
   logic timerOn;
   logic running;
   logic [5:0] preLast;
   logic tick;
   logic match;
   logic postDone;
   logic wrCount;
   logic wrPeriod;
   logic wrControl;
   logic wrIrqFlag;
   logic wrIrqEnable;
   logic reload;
   logic [7:0] count_d;
   logic [7:0] period_d;
   logic [6:0] control_d;
   logic [5:0] preCnt_d;
   logic [3:0] postCnt_d;
   logic matchFlag_d;
   logic irqEnable_d;
   logic reloadPending_d;
   logic [7:0] regRdData_d;

   assign preSel = control_q[period_timer_pkg::CTL_PRE_LSB +: 2];
   assign postSel = control_q[period_timer_pkg::CTL_POST_LSB +: 4];
   assign timerOn = control_q[period_timer_pkg::CTL_ON_BIT];

   // The instruction clock is clk itself; the timer is gated by on and
   // by sleep so that nothing moves while either holds it.
   assign running = timerOn && !sleep;

   assign wrCount = regWrite && (regAddr == period_timer_pkg::ADDR_COUNT);
   assign wrPeriod = regWrite && (regAddr == period_timer_pkg::ADDR_PERIOD);
   assign wrControl = regWrite &&
                      (regAddr == period_timer_pkg::ADDR_CONTROL);
   assign wrIrqFlag = regWrite &&
                      (regAddr == period_timer_pkg::ADDR_IRQ_FLAG);
   assign wrIrqEnable = regWrite &&
                        (regAddr == period_timer_pkg::ADDR_IRQ_ENABLE);

   // ------------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------------
   always_comb
   begin
      unique case (preSel)
         2'b00: preLast = period_timer_pkg::PRE_LAST_DIV1;
         2'b01: preLast = period_timer_pkg::PRE_LAST_DIV4;
         2'b10: preLast = period_timer_pkg::PRE_LAST_DIV16;
         2'b11: preLast = period_timer_pkg::PRE_LAST_DIV64;
      endcase
   end

   // The terminal test is a greater-or-equal, but a ratio lowered in mid-count
   // comes with the control write that restarts the prescaler at zero.
   assign tick = running && (preCnt_q >= preLast);

   // The prescaler restarts on each tick and on the writes that must
   // clear it; it holds while the timer is off or asleep.
   always_comb
   begin
      preCnt_d = preCnt_q;
      if (wrCount || wrControl)
         preCnt_d = 6'h00;
      else if (tick)
         preCnt_d = 6'h00;
      else if (running)
         preCnt_d = preCnt_q + 6'h01;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         preCnt_q <= 6'h00;
      else
         preCnt_q <= preCnt_d;
   end

   // ------------------------------------------------------------------
   // Count and comparator
   // ------------------------------------------------------------------
   // The comparator looks every cycle. The match is reported once per
   // period: with a slow prescaler the count rests on the period value
   // for several cycles, and the pending flag masks all but the first.
   assign match = running && (count_q == period_q) &&
                  !reloadPending_q;

   // The first tick that finds the count on the period value reloads
   // it, so one period lasts the period value plus one ticks.
   assign reload = tick && (count_q == period_q);

   always_comb
   begin
      reloadPending_d = reloadPending_q;
      if (wrCount || wrPeriod)
         reloadPending_d = 1'b0;
      else if (match)
         reloadPending_d = 1'b1;
      else if (tick)
         reloadPending_d = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         reloadPending_q <= 1'b0;
      else
         reloadPending_q <= reloadPending_d;
   end

   // A software write of the count wins over a reload in the same cycle.
   always_comb
   begin
      count_d = count_q;
      if (wrCount)
         count_d = regWrData;
      else if (reload)
         count_d = period_timer_pkg::COUNT_RESET;
      else if (tick)
         count_d = count_q + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         count_q <= period_timer_pkg::COUNT_RESET;
      else
         count_q <= count_d;
   end

   always_comb
   begin
      period_d = period_q;
      if (wrPeriod)
         period_d = regWrData;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         period_q <= period_timer_pkg::PERIOD_RESET;
      else
         period_q <= period_d;
   end

   // ------------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------------
   // Bit seven is not stored, so it always reads back as zero. A write
   // here never touches the count; only the scalers restart.
   always_comb
   begin
      control_d = control_q;
      if (wrControl)
         control_d = regWrData[6:0];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         control_q <= period_timer_pkg::CONTROL_RESET;
      else
         control_q <= control_d;
   end

   // ------------------------------------------------------------------
   // Postscaler and match flag
   // ------------------------------------------------------------------
   // The postscaler counts match pulses; the pulse that finds it on the
   // selected value completes the ratio of the field value plus one.
   assign postDone = match && (postCnt_q == postSel);

   always_comb
   begin
      postCnt_d = postCnt_q;
      if (wrCount || wrControl)
         postCnt_d = 4'h0;
      else if (postDone)
         postCnt_d = 4'h0;
      else if (match)
         postCnt_d = postCnt_q + 4'h1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         postCnt_q <= 4'h0;
      else
         postCnt_q <= postCnt_d;
   end

   // A completion in the cycle of a software clear still sets the flag.
   always_comb
   begin
      matchFlag_d = matchFlag_q;
      if (postDone)
         matchFlag_d = 1'b1;
      else if (wrIrqFlag)
         matchFlag_d =
            regWrData[period_timer_pkg::IRQ_MATCH_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         matchFlag_q <= 1'b0;
      else
         matchFlag_q <= matchFlag_d;
   end

   always_comb
   begin
      irqEnable_d = irqEnable_q;
      if (wrIrqEnable)
         irqEnable_d = regWrData[period_timer_pkg::IRQ_MATCH_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         irqEnable_q <= 1'b0;
      else
         irqEnable_q <= irqEnable_d;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         irqRequest_q <= 1'b0;
      else
         irqRequest_q <= matchFlag_q && irqEnable_q;
   end

   // ------------------------------------------------------------------
   // Time base outputs
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         periodMatch_q <= 1'b0;
      else
         periodMatch_q <= match;
   end

   // Marks the tick on which the count reloads: PWM outputs go active
   // and duty buffers latch here.
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         pwmPeriodStart_q <= 1'b0;
      else
         pwmPeriodStart_q <= reload && !wrCount;
   end

   // ------------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------------
   // Read data stand for the one cycle after the strobe and are zero
   // otherwise, so a stale value can never be mistaken for an answer.
   // Indices beyond the map read as zero.
   always_comb
   begin
      regRdData_d = 8'h00;
      if (regRead)
      begin
         unique case (regAddr)
            period_timer_pkg::ADDR_COUNT: regRdData_d = count_q;
            period_timer_pkg::ADDR_PERIOD: regRdData_d = period_q;
            period_timer_pkg::ADDR_CONTROL:
               regRdData_d = {1'b0, control_q};
            period_timer_pkg::ADDR_IRQ_FLAG:
               regRdData_d = {6'h00, matchFlag_q, 1'b0};
            period_timer_pkg::ADDR_IRQ_ENABLE:
               regRdData_d = {6'h00, irqEnable_q, 1'b0};
            default: regRdData_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         regRdData_q <= 8'h00;
      else
         regRdData_q <= regRdData_d;
   end

   assign regRdData = regRdData_q;
   assign periodMatch = periodMatch_q;
   assign pwmPeriodStart = pwmPeriodStart_q;
   assign irqRequest = irqRequest_q;

endmodule : period_match_timer

`default_nettype wire

// [rtl/period_timer_pkg.sv]
// Package with register map, field layout and reset values of the timer.
package period_timer_pkg;

   // ------------------------------------------------------------------
   // Register indices
   // ------------------------------------------------------------------
   localparam logic [2:0] ADDR_COUNT = 3'h0;
   localparam logic [2:0] ADDR_PERIOD = 3'h1;
   localparam logic [2:0] ADDR_CONTROL = 3'h2;
   localparam logic [2:0] ADDR_IRQ_FLAG = 3'h3;
   localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h4;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTL_PRE_LSB = 0;
   localparam int CTL_ON_BIT = 2;
   localparam int CTL_POST_LSB = 3;
   localparam int IRQ_MATCH_BIT = 1;

   // ------------------------------------------------------------------
   // Reset values and divider terminal counts
   // ------------------------------------------------------------------
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] PERIOD_RESET = 8'hFF;
   localparam logic [6:0] CONTROL_RESET = 7'h00;
   localparam logic [5:0] PRE_LAST_DIV1 = 6'h00;
   localparam logic [5:0] PRE_LAST_DIV4 = 6'h03;
   localparam logic [5:0] PRE_LAST_DIV16 = 6'h0F;
   localparam logic [5:0] PRE_LAST_DIV64 = 6'h3F;

endpackage : period_timer_pkg

// [test/period_match_timer_checker.sv]
// Concurrent checks on the ports of the period match timer.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer_checker
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sleep,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic periodMatch,
   input wire logic pwmPeriodStart,
   input wire logic irqRequest
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_off_wr;
      regWrite && regAddr == period_timer_pkg::ADDR_CONTROL && !regWrData[2];
   endsequence
   sequence s_mask_wr;
      regWrite && regAddr == period_timer_pkg::ADDR_IRQ_ENABLE &&
      !regWrData[1];
   endsequence
   property p_rd_idle;
      !regRead |=> regRdData == 8'h00;
   endproperty
   property p_ctl_msb;
      regRead && regAddr == period_timer_pkg::ADDR_CONTROL |=> !regRdData[7];
   endproperty
   property p_unmapped;
      regRead && regAddr > period_timer_pkg::ADDR_IRQ_ENABLE |=>
         regRdData == 8'h00;
   endproperty
   property p_pulse;
      periodMatch |=> !periodMatch;
   endproperty
   property p_sleep;
      sleep [*3] |-> !periodMatch && !pwmPeriodStart;
   endproperty
   property p_mask;
      s_mask_wr |-> ##2 !irqRequest [*2];
   endproperty
   property p_off;
      s_off_wr |-> ##2 !periodMatch [*4];
   endproperty
   property p_sep;
      pwmPeriodStart |=> !pwmPeriodStart;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not idle");
   a_ctl_msb: assert property (p_ctl_msb)
      else $error("control msb set");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read");
   a_pulse: assert property (p_pulse)
      else $error("match pulse long");
   a_sleep: assert property (p_sleep)
      else $error("match in sleep");
   a_mask: assert property (p_mask)
      else $error("irq not masked");
   a_off: assert property (p_off)
      else $error("match while off");
   a_sep: assert property (p_sep)
      else $error("period start pulse long");
endmodule : period_match_timer_checker
bind period_match_timer period_match_timer_checker u_chk (.clk(clk),
   .rst_n(rst_n), .sleep(sleep), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
   .periodMatch(periodMatch), .pwmPeriodStart(pwmPeriodStart),
   .irqRequest(irqRequest));
`default_nettype wire

// [test/period_match_timer_tb.sv]
// Self-checking testbench for the period match timer.
`timescale 1ns/1ps
`default_nettype none
module period_match_timer_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sleep = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdData;
   logic periodMatch, pwmPeriodStart, irqRequest;
   int err_total = 0;
   int total_checks = 0;
   int pwmLen;
   always #50 clk = ~clk;
   period_match_timer uut (.clk(clk), .rst_n(rst_n), .sleep(sleep),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData), .periodMatch(periodMatch),
      .pwmPeriodStart(pwmPeriodStart), .irqRequest(irqRequest));
   pwm_channel_model pwm (.clk(clk), .pwmPeriodStart(pwmPeriodStart),
      .periodLen(pwmLen));
   task automatic report_and_stop;
      if (err_total == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string s, input logic [7:0] e,
      input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      d = regRdData;
   endtask : rd
   task automatic rdchk(input string s, input logic [2:0] a,
      input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(s, e, v);
   endtask : rdchk
   task automatic t_regs;
      rdchk("count", period_timer_pkg::ADDR_COUNT, 8'h00);
      rdchk("period", period_timer_pkg::ADDR_PERIOD, 8'hFF);
      rdchk("control", period_timer_pkg::ADDR_CONTROL, 8'h00);
      rdchk("unmapped", 3'h5, 8'h00);
      wr(period_timer_pkg::ADDR_COUNT, 8'h33);
      wr(period_timer_pkg::ADDR_PERIOD, 8'h5A);
      wr(period_timer_pkg::ADDR_CONTROL, 8'hFB);
      rdchk("period rw", period_timer_pkg::ADDR_PERIOD, 8'h5A);
      rdchk("control rw", period_timer_pkg::ADDR_CONTROL, 8'h7B);
      rdchk("count held", period_timer_pkg::ADDR_COUNT, 8'h33);
   endtask : t_regs
   // Cycles from one match pulse to the next, after skipping to a pulse.
   task automatic per(output int n);
      n = 0;
      @(negedge clk);
      for (int i = 0; i < 700 && periodMatch !== 1'b1; i++)
         @(negedge clk);
      do
      begin
         @(negedge clk);
         n++;
      end
      while (periodMatch !== 1'b1 && n < 700);
   endtask : per
   task automatic t_div;
      int n;
      wr(period_timer_pkg::ADDR_PERIOD, 8'h02);
      for (int c = 0; c < 4; c++)
      begin
         wr(period_timer_pkg::ADDR_CONTROL, 8'h04 | 8'(c));
         per(n);
         chk("period cycles", 8'h03 << (c + c), 8'(n));
      end
   endtask : t_div
   task automatic t_post;
      int n;
      wr(period_timer_pkg::ADDR_PERIOD, 8'h07);
      wr(period_timer_pkg::ADDR_IRQ_ENABLE, 8'h02);
      for (int k = 0; k < 16; k += 5)
      begin
         wr(period_timer_pkg::ADDR_CONTROL, 8'(k) << 3);
         wr(period_timer_pkg::ADDR_IRQ_FLAG, 8'h00);
         wr(period_timer_pkg::ADDR_CONTROL, (8'(k) << 3) | 8'h04);
         n = 0;
         @(negedge clk);
         for (int i = 0; i < 300 && irqRequest !== 1'b1; i++)
         begin
            @(negedge clk);
            n += (periodMatch === 1'b1);
         end
         chk("postscale", 8'(k + 1), 8'(n));
      end
      chk("pwm period", 8'h08, 8'(pwmLen));
      rdchk("flag held", period_timer_pkg::ADDR_IRQ_FLAG, 8'h02);
      wr(period_timer_pkg::ADDR_IRQ_ENABLE, 8'h00);
      repeat (3) @(negedge clk);
      chk("irq masked", 8'h00, {7'h00, irqRequest});
   endtask : t_post
   task automatic t_sleep;
      logic [7:0] a, b;
      @(posedge clk);
      sleep <= 1'b1;
      rd(period_timer_pkg::ADDR_COUNT, a);
      repeat (20) @(posedge clk);
      rd(period_timer_pkg::ADDR_COUNT, b);
      chk("sleep count", a, b);
      @(posedge clk);
      sleep <= 1'b0;
   endtask : t_sleep
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_div();
      t_post();
      t_sleep();
      report_and_stop();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      report_and_stop();
   end
endmodule : period_match_timer_tb
`default_nettype wire

// [test/pwm_channel_model.sv]
// Behavioural PWM channel timed by the timer's period start pulse.
`timescale 1ns/1ps
`default_nettype none
module pwm_channel_model
(
   input wire logic clk,
   input wire logic pwmPeriodStart,
   output var int periodLen
);
   int run = 0;
   // Each start pulse opens a new period, so the gap is the period length.
   always @(posedge clk)
      if (pwmPeriodStart === 1'b1)
      begin
         periodLen <= run + 1;
         run <= 0;
      end
      else
         run <= run + 1;
endmodule : pwm_channel_model
`default_nettype wire
